// ### pkg/scan_seq_regs.vh
// Contract
// - Reset leaves sequencer idle, triggers unused.
// - Arm command moves idle to armed.
// - Armed trigger opens current, closes next relay.
// - Count passes; at repeat count return idle.
// - Idle discards triggers, relays untouched.
// - Hold source ignores all triggers except immediate.
// - Immediate command overrides hold, skips delay.
// - First trigger closes first relay only.
// - Trigger after final pass opens last, idles.
// - Identification lists host card, then rightward.
// - Delay, open, dwell, close, dwell, pulse 3 us.
// - Close dwell per module, 0-6.5535 s, reset zero.
`ifndef SCAN_SEQ_REGS_VH
`define SCAN_SEQ_REGS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_CTRL 12'h000
`define OFS_SOURCE 12'h004
`define OFS_COUNT 12'h008
`define OFS_LEN 12'h00C
`define OFS_TDELAY 12'h010
`define OFS_ODWELL 12'h014
`define OFS_TTL_EN 12'h018
`define OFS_STATUS 12'h01C
`define OFS_CDWELL 12'h040
`define OFS_ID_CNT 12'h07C
`define OFS_ID 12'h080
`define OFS_LIST 12'h100

// ----------------------------------------
// Control bits (write one to act)
// ----------------------------------------
`define CTRL_ARM 0
`define CTRL_ABORT 1
`define CTRL_IMM 2
`define CTRL_BUS 3
`define CTRL_COMMON 4

// ----------------------------------------
// Trigger source codes and fields
// ----------------------------------------
`define SRC_HOLD 2'h0
`define SRC_LINE 2'h1
`define SRC_BUS 2'h2
`define SRC_FREE 2'h3
`define SRC_SEL_LSB 4
`define SRC_SEL_MSB 6

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_NS 10
`define CLK_MHZ 100
`define TICK_US 100
`define TICK_CYC (`TICK_US * `CLK_MHZ)
`define PULSE_NS 3000
`define PULSE_CYC ((`PULSE_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// ### rtl/scan_list_mem.v
`timescale 1ns/1ps
`include "scan_seq_regs.vh"

// ----------------------------------------
// Scan list storage, one write and one read port
// ----------------------------------------
module scan_list_mem #(
	parameter DEPTH = 64,
	parameter AW = 6,
	parameter DW = 8
) (
	input wire clk_sys,
	input wire wr_en,
	input wire [AW-1:0] wr_addr,
	input wire [DW-1:0] wr_data,
	input wire [AW-1:0] rd_addr,
	output reg [DW-1:0] rd_data
);

	// Storage array, no reset: software fills it before arming
	reg [DW-1:0] mem [0:DEPTH-1];

	// Write port and registered read port
	always @(posedge clk_sys) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end

endmodule

// ### rtl/relay_scan_trigger_sequencer.v
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "scan_seq_regs.vh"

// ----------------------------------------
// Trigger-driven relay scan sequencer
// ----------------------------------------
module relay_scan_trigger_sequencer #(
	parameter NMOD = 4,
	parameter MW = 2,
	parameter NLINE = 8,
	parameter DEPTH = 64,
	parameter AW = 6,
	parameter TICK_CYC = `TICK_CYC
) (
	input wire clk_sys,
	input wire srst,
	input wire [11:0] addr,
	input wire [31:0] wdata,
	input wire wr,
	input wire rd,
	output reg [31:0] rdata,
	input wire [NLINE-1:0] ttl_i,
	output wire [NLINE-1:0] ttl_o,
	output wire [NLINE-1:0] ttl_oe,
	input wire [NMOD*16-1:0] card_id,
	input wire [NMOD-1:0] card_present,
	output reg relay_open,
	output reg relay_close,
	output reg [MW+5:0] relay_addr
);

	// ----------------------------------------
	// States, one-hot
	// ----------------------------------------
	localparam [7:0] ST_IDLE = 8'h01;
	localparam [7:0] ST_ARMED = 8'h02;
	localparam [7:0] ST_TDLY = 8'h04;
	localparam [7:0] ST_OPEN = 8'h08;
	localparam [7:0] ST_ODW = 8'h10;
	localparam [7:0] ST_CLOSE = 8'h20;
	localparam [7:0] ST_CDW = 8'h40;
	localparam [7:0] ST_PULSE = 8'h80;
	localparam [15:0] PULSE_CYC = `PULSE_CYC;
	localparam [31:0] TICK_LAST = TICK_CYC - 1;

	// Module field of a scan list entry
	function [MW-1:0] ent_mod;
		input [MW+5:0] ent;
		begin
			ent_mod = ent[MW+5:6];
		end
	endfunction

	// ----------------------------------------
	// Software-visible state
	// ----------------------------------------
	reg [7:0] state_r; // Sequencer state
	reg [1:0] src_r; // Trigger source
	reg [2:0] line_sel_r; // Backplane line used as input
	reg [15:0] count_r; // Repeat count of passes
	reg [AW:0] len_r; // Entries in the scan list
	reg [15:0] tdelay_r; // Trigger delay, ticks
	reg [15:0] odwell_r; // Open dwell, ticks
	reg [NLINE-1:0] ttl_en_r; // Lines pulsed after a step
	reg [15:0] cdwell_r [0:NMOD-1]; // Close dwell per module
	reg [AW-1:0] pos_r; // Next entry to close
	reg [15:0] pass_r; // Completed passes
	reg closed_r; // Scan holds a relay closed
	reg [MW+5:0] cur_r; // Entry now closed
	reg [15:0] wait_r; // Ticks left in a wait
	reg [31:0] div_r; // Tick divider
	reg [15:0] pcnt_r; // Cycles left of the line pulse
	reg [NLINE-1:0] s1_r, s2_r, s3_r; // Line synchronisers
	reg [NLINE-1:0] filt_r; // Filtered line level
	wire [MW+5:0] ent; // Entry at pos_r, one cycle late
	integer i; // Synchroniser loop index
	integer j; // Configuration loop index
	integer k; // Chain loop index
	integer n; // Read decode loop index

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	wire wr_ctrl = wr && addr == `OFS_CTRL;
	wire cmd_arm = wr_ctrl && wdata[`CTRL_ARM];
	wire cmd_abort = wr_ctrl && wdata[`CTRL_ABORT];
	wire cmd_imm = wr_ctrl && wdata[`CTRL_IMM];
	wire cmd_bus = wr_ctrl && (wdata[`CTRL_BUS] || wdata[`CTRL_COMMON]);
	wire list_wr = wr && addr[11:8] == `OFS_LIST >> 8 && addr[1:0] == 2'h0 &&
		addr[7:2] < DEPTH;
	wire tick = div_r == TICK_LAST;

	// ----------------------------------------
	// Scan list memory
	// ----------------------------------------
	scan_list_mem #(.DEPTH(DEPTH), .AW(AW), .DW(MW + 6)) u_list (
		.clk_sys(clk_sys),
		.wr_en(list_wr),
		.wr_addr(addr[AW+1:2]),
		.wr_data(wdata[MW+5:0]),
		.rd_addr(pos_r),
		.rd_data(ent)
	);

	// ----------------------------------------
	// Backplane line input, falling edge
	// ----------------------------------------
	// A line counts as low once the second and third stages agree
	wire [NLINE-1:0] fall = filt_r & ~s2_r & ~s3_r;
	always @(posedge clk_sys) begin
		if (srst) begin
			s1_r <= {NLINE{1'b1}};
			s2_r <= {NLINE{1'b1}};
			s3_r <= {NLINE{1'b1}};
			filt_r <= {NLINE{1'b1}};
		end else begin
			s1_r <= ttl_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
			for (i = 0; i < NLINE; i = i + 1) begin
				if (s2_r[i] == s3_r[i]) begin
					filt_r[i] <= s3_r[i];
				end
			end
		end
	end

	// ----------------------------------------
	// Trigger qualification
	// ----------------------------------------
	// Hold blocks every source but the immediate command
	// hold blocks sources
	wire src_evt = (src_r == `SRC_LINE && fall[line_sel_r]) ||
		(src_r == `SRC_BUS && cmd_bus) || src_r == `SRC_FREE;
	wire trig = cmd_imm || src_evt;
	wire done = pass_r >= count_r;

	// ----------------------------------------
	// Line pulse outputs, open drain, active low
	// ----------------------------------------
	// pulse enabled lines
	assign ttl_oe = state_r == ST_PULSE ? ttl_en_r : {NLINE{1'b0}};
	assign ttl_o = {NLINE{1'b0}};

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	always @(posedge clk_sys) begin
		if (srst) begin
			src_r <= `SRC_HOLD;
			line_sel_r <= 3'h0;
			count_r <= 16'h0001;
			len_r <= {(AW+1){1'b0}};
			tdelay_r <= 16'h0000;
			odwell_r <= 16'h0000;
			ttl_en_r <= {NLINE{1'b0}};
			for (j = 0; j < NMOD; j = j + 1) begin
				cdwell_r[j] <= 16'h0000;
			end
		end else if (wr) begin
			case (addr)
				`OFS_SOURCE: begin
					src_r <= wdata[1:0];
					line_sel_r <= wdata[`SRC_SEL_MSB:`SRC_SEL_LSB];
				end
				`OFS_COUNT: count_r <= wdata[15:0];
				`OFS_LEN: len_r <= wdata[AW:0];
				`OFS_TDELAY: tdelay_r <= wdata[15:0];
				`OFS_ODWELL: odwell_r <= wdata[15:0];
				`OFS_TTL_EN: ttl_en_r <= wdata[NLINE-1:0];
				default: begin
					for (j = 0; j < NMOD; j = j + 1) begin
						if (addr == `OFS_CDWELL + 4 * j) begin
							cdwell_r[j] <= wdata[15:0];
						end
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	// Waits count 100 us ticks; the divider restarts on each load
	always @(posedge clk_sys) begin
		if (srst) begin
			state_r <= ST_IDLE;
			pos_r <= {AW{1'b0}};
			pass_r <= 16'h0000;
			closed_r <= 1'b0;
			cur_r <= {(MW+6){1'b0}};
			wait_r <= 16'h0000;
			div_r <= 32'h0;
			pcnt_r <= 16'h0000;
			relay_open <= 1'b0;
			relay_close <= 1'b0;
			relay_addr <= {(MW+6){1'b0}};
		end else begin
			relay_open <= 1'b0;
			relay_close <= 1'b0;
			div_r <= tick ? 32'h0 : div_r + 32'h1;
			if (tick && wait_r != 16'h0000) begin
				wait_r <= wait_r - 16'h0001;
			end
			if (cmd_abort) begin
				state_r <= ST_IDLE;
			end else begin
				case (state_r)
					ST_IDLE: begin
						if (cmd_arm) begin
							state_r <= ST_ARMED;
							pos_r <= {AW{1'b0}};
							pass_r <= 16'h0000;
							closed_r <= 1'b0;
						end
					end
					ST_ARMED: begin
						if (trig) begin
							div_r <= 32'h0;
							wait_r <= cmd_imm ? 16'h0000 : tdelay_r;
							state_r <= ST_TDLY;
						end
					end
					ST_TDLY: begin
						if (wait_r == 16'h0000) begin
							state_r <= ST_OPEN;
						end
					end
					ST_OPEN: begin
						div_r <= 32'h0;
						if (closed_r) begin
							relay_open <= 1'b1;
							relay_addr <= cur_r;
							closed_r <= 1'b0;
							wait_r <= odwell_r;
						end else begin
							wait_r <= 16'h0000;
						end
						if (done) begin
							state_r <= ST_IDLE;
						end else begin
							state_r <= ST_ODW;
						end
					end
					ST_ODW: begin
						if (wait_r == 16'h0000) begin
							state_r <= ST_CLOSE;
						end
					end
					ST_CLOSE: begin
						relay_close <= 1'b1;
						relay_addr <= ent;
						cur_r <= ent;
						closed_r <= 1'b1;
						div_r <= 32'h0;
						wait_r <= cdwell_r[ent_mod(ent)];
						if ({1'b0, pos_r} + {{AW{1'b0}}, 1'b1} >= len_r) begin
							pos_r <= {AW{1'b0}};
							pass_r <= pass_r + 16'h0001;
						end else begin
							pos_r <= pos_r + {{(AW-1){1'b0}}, 1'b1};
						end
						state_r <= ST_CDW;
					end
					ST_CDW: begin
						if (wait_r == 16'h0000) begin
							pcnt_r <= PULSE_CYC;
							state_r <= ST_PULSE;
						end
					end
					ST_PULSE: begin
						if (pcnt_r == 16'h0001) begin
							state_r <= ST_ARMED;
						end else begin
							pcnt_r <= pcnt_r - 16'h0001;
						end
					end
					default: state_r <= ST_IDLE;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Card chain for identification
	// ----------------------------------------
	// Chain ends at the first empty slot to the right of the host card
	reg [NMOD-1:0] chain;
	reg [7:0] chain_cnt;
	always @* begin
		chain = {NMOD{1'b0}};
		chain_cnt = 8'h00;
		for (k = 0; k < NMOD; k = k + 1) begin
			if (card_present[k] && (k == 0 || chain[(k == 0) ? 0 : k - 1])) begin
				chain[k] = 1'b1;
				chain_cnt = chain_cnt + 8'h01;
			end
		end
	end

	// ----------------------------------------
	// Read data, one cycle after the strobe
	// ----------------------------------------
	reg [31:0] rd_nxt;
	always @* begin
		rd_nxt = 32'h0;
		case (addr)
			`OFS_SOURCE: rd_nxt = {25'h0, line_sel_r, 2'h0, src_r};
			`OFS_COUNT: rd_nxt = {16'h0, count_r};
			`OFS_LEN: rd_nxt[AW:0] = len_r;
			`OFS_TDELAY: rd_nxt = {16'h0, tdelay_r};
			`OFS_ODWELL: rd_nxt = {16'h0, odwell_r};
			`OFS_TTL_EN: rd_nxt[NLINE-1:0] = ttl_en_r;
			`OFS_STATUS: begin
				rd_nxt[0] = state_r != ST_IDLE;
				rd_nxt[1] = state_r != ST_IDLE && state_r != ST_ARMED;
				rd_nxt[2] = closed_r;
				rd_nxt[AW+7:8] = pos_r;
				rd_nxt[31:16] = pass_r;
			end
			`OFS_ID_CNT: rd_nxt = {24'h0, chain_cnt};
			default: begin
				for (n = 0; n < NMOD; n = n + 1) begin
					if (addr == `OFS_CDWELL + 4 * n) begin
						rd_nxt = {16'h0, cdwell_r[n]};
					end
					if (addr == `OFS_ID + 4 * n && chain[n]) begin
						rd_nxt = {16'h0, card_id[n*16 +: 16]};
					end
				end
			end
		endcase
	end

	always @(posedge clk_sys) begin
		if (srst) begin
			rdata <= 32'h0;
		end else if (rd) begin
			rdata <= rd_nxt;
		end
	end

endmodule

// ### test/scan_seq_properties.sv
`timescale 1ns/1ps
`include "scan_seq_regs.vh"

// ----------------------------------------
// Port checks of the scan sequencer
// ----------------------------------------
module scan_seq_properties #(
	parameter NMOD = 4,
	parameter NLINE = 8
) (
	input wire clk_sys,
	input wire srst,
	input wire [11:0] addr,
	input wire rd,
	input wire [31:0] rdata,
	input wire [NLINE-1:0] ttl_o,
	input wire [NLINE-1:0] ttl_oe,
	input wire [NMOD*16-1:0] card_id,
	input wire [NMOD-1:0] card_present,
	input wire relay_open,
	input wire relay_close
);
	// Cycles the line pulse has stood so far
	reg [9:0] oe_cnt_r;

	// Count pulse length, cleared between pulses
	always @(posedge clk_sys) begin
		if (srst || ~|ttl_oe)
			oe_cnt_r <= 10'h000;
		else
			oe_cnt_r <= oe_cnt_r + 10'h001;
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);

	a_reset_quiet: assert property (disable iff (1'b0)
		srst |=> (rdata == 32'h0 && ttl_oe == 0 && !relay_open && !relay_close))
		else $error("outputs not quiet after reset");
	a_one_action: assert property (!(relay_open && relay_close))
		else $error("open and close in one cycle");
	a_close_single: assert property (relay_close |=> !relay_close)
		else $error("close pulse too long");
	a_open_single: assert property (relay_open |=> !relay_open)
		else $error("open pulse too long");
	a_open_drain: assert property (ttl_o == 0)
		else $error("line drive value not low");
	a_pulse_len: assert property ($fell(|ttl_oe) |-> oe_cnt_r == 10'h12C)
		else $error("line pulse length wrong");
	a_pulse_alone: assert property (|ttl_oe |-> !relay_open && !relay_close)
		else $error("relay moved during line pulse");
	a_id_first: assert property (
		rd && addr == `OFS_ID && card_present[0] |=> rdata == {16'h0000, $past(card_id[15:0])})
		else $error("host card id wrong");
	a_id_count: assert property (
		rd && addr == `OFS_ID_CNT && (&card_present) |=> rdata == NMOD)
		else $error("chain length wrong");

	c_close: cover property (relay_close);
	c_open: cover property (relay_open);
	c_pulse: cover property ($fell(|ttl_oe));
endmodule

bind relay_scan_trigger_sequencer scan_seq_properties #(.NMOD(NMOD), .NLINE(NLINE)) chk (
	.clk_sys(clk_sys), .srst(srst), .addr(addr), .rd(rd), .rdata(rdata),
	.ttl_o(ttl_o), .ttl_oe(ttl_oe), .card_id(card_id), .card_present(card_present),
	.relay_open(relay_open), .relay_close(relay_close));

// ### test/trig_line_model.sv
`timescale 1ns/1ps

// ----------------------------------------
// Backplane trigger lines with pull-ups
// ----------------------------------------
module trig_line_model #(
	parameter NLINE = 8
) (
	input wire [NLINE-1:0] ttl_oe,
	input wire [NLINE-1:0] pull,
	output wire [NLINE-1:0] line
);
	// idle high, low while any party drives
	assign line = ~(ttl_oe | pull);
endmodule

// ### test/tb_top.sv
`timescale 1ns/1ps
`include "scan_seq_regs.vh"

// ----------------------------------------
// Scan sequencer testbench
// ----------------------------------------
module tb_top;
	reg clk_sys;
	reg srst;
	reg [11:0] addr;
	reg [31:0] wdata;
	reg wr;
	reg rd;
	reg [7:0] pull; // Bench pulls a line low
	wire [7:0] ttl_i;
	wire [7:0] ttl_o;
	wire [7:0] ttl_oe;
	wire [31:0] rdata;
	wire relay_open;
	wire relay_close;
	wire [7:0] relay_addr;
	// Model ids of the slots, values arbitrary
	wire [63:0] card_id = 64'h4444_3333_2222_1111;
	integer miscompares, total_checks, n_open, n_close, n_oe, i;
	reg [7:0] last_open, last_close;
	reg [31:0] st;

	relay_scan_trigger_sequencer #(.TICK_CYC(4)) uut (
		.clk_sys(clk_sys), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .ttl_i(ttl_i), .ttl_o(ttl_o), .ttl_oe(ttl_oe), .card_id(card_id),
		.card_present(4'hF), .relay_open(relay_open), .relay_close(relay_close),
		.relay_addr(relay_addr));

	trig_line_model #(.NLINE(8)) lines (.ttl_oe(ttl_oe), .pull(pull), .line(ttl_i));

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// Relay and line pulse recorder
	always @(posedge clk_sys) begin
		if (relay_open) begin
			n_open <= n_open + 1;
			last_open <= relay_addr;
		end
		if (relay_close) begin
			n_close <= n_close + 1;
			last_close <= relay_addr;
		end
		if (ttl_oe[1])
			n_oe <= n_oe + 1;
	end

	task wr_reg(input [11:0] a, input [31:0] d);
		begin
			@(posedge clk_sys);
			addr <= a;
			wdata <= d;
			wr <= 1'b1;
			@(posedge clk_sys);
			wr <= 1'b0;
		end
	endtask

	// Data appear in the cycle after the strobe and hold until the next read strobe
	task rd_reg(input [11:0] a, output [31:0] d);
		begin
			@(posedge clk_sys);
			addr <= a;
			rd <= 1'b1;
			@(posedge clk_sys);
			rd <= 1'b0;
			#1 d = rdata;
		end
	endtask

	task check(input [31:0] seen, input [31:0] exp);
		begin
			total_checks = total_checks + 1;
			if (seen !== exp) begin
				$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
				miscompares = miscompares + 1;
			end
		end
	endtask

	// Falling edge on line 2, then time for sync and delay
	task line_trig;
		begin
			@(posedge clk_sys);
			pull <= 8'h04;
			repeat (3) @(posedge clk_sys);
			pull <= 8'h00;
			repeat (40) @(posedge clk_sys);
		end
	endtask

	// Poll until no step is running, bounded
	task step_wait;
		begin
			st = 32'h2;
			for (i = 0; i < 1000 && st[1]; i = i + 1)
				rd_reg(`OFS_STATUS, st);
			if (st[1])
				miscompares = miscompares + 1;
		end
	endtask

	task end_of_test;
		begin
			if (miscompares == 0 && total_checks > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask

	initial begin
		#100000;
		miscompares = miscompares + 1;
		end_of_test;
	end

	initial begin
		srst = 1'b1;
		addr = 12'h000;
		wdata = 32'h0;
		wr = 1'b0;
		rd = 1'b0;
		pull = 8'h00;
		miscompares = 0;
		total_checks = 0;
		n_open = 0;
		n_close = 0;
		n_oe = 0;
		repeat (8) @(posedge clk_sys);
		srst <= 1'b0;
		rd_reg(`OFS_STATUS, st);
		check(st, 32'h0);
		for (i = 0; i < 4; i = i + 1) begin
			rd_reg(`OFS_ID + 4 * i, st);
			check(st, {16'h0000, card_id[16*i +: 16]});
		end
		rd_reg(`OFS_ID_CNT, st);
		check(st, 32'h4);
		rd_reg(`OFS_CDWELL + 12'h004, st);
		check(st, 32'h0);
		// Commands while idle must leave relays alone
		wr_reg(`OFS_CTRL, 32'h1C);
		repeat (10) @(posedge clk_sys);
		check(n_open + n_close, 32'h0);
		wr_reg(`OFS_LEN, 32'h2);
		wr_reg(`OFS_COUNT, 32'h1);
		wr_reg(`OFS_LIST, 32'h05);
		wr_reg(`OFS_LIST + 12'h004, 32'h47);
		wr_reg(`OFS_TDELAY, 32'h5);
		wr_reg(`OFS_TTL_EN, 32'h2);
		wr_reg(`OFS_SOURCE, 32'h20);
		wr_reg(`OFS_CTRL, 32'h1);
		rd_reg(`OFS_STATUS, st);
		check(st & 32'h1, 32'h1);
		// Hold source: bus, common and line triggers all dropped
		wr_reg(`OFS_CTRL, 32'h18);
		line_trig;
		check(n_close, 32'h0);
		// Immediate beats hold and skips the 20-cycle delay
		wr_reg(`OFS_CTRL, 32'h4);
		repeat (8) @(posedge clk_sys);
		check(n_close, 32'h1);
		wr_reg(`OFS_CTRL, 32'h4);
		step_wait;
		check(n_close, 32'h1);
		check(n_open, 32'h0);
		check(last_close, 8'h05);
		check(n_oe, 32'd300);
		wr_reg(`OFS_SOURCE, 32'h21);
		line_trig;
		step_wait;
		check(n_open, 32'h1);
		check(last_open, 8'h05);
		check(n_close, 32'h2);
		check(last_close, 8'h47);
		wr_reg(`OFS_CTRL, 32'h4);
		step_wait;
		check(n_open, 32'h2);
		check(last_open, 8'h47);
		check(n_close, 32'h2);
		rd_reg(`OFS_STATUS, st);
		check(st & 32'h1, 32'h0);
		// Bus source: a bus trigger command starts a new scan
		wr_reg(`OFS_SOURCE, 32'h2);
		wr_reg(`OFS_CTRL, 32'h1);
		wr_reg(`OFS_CTRL, 32'h8);
		step_wait;
		check(n_close, 32'h3);
		check(last_close, 8'h05);
		check(n_open, 32'h2);
		// Free-run source finishes the list on its own
		wr_reg(`OFS_SOURCE, 32'h3);
		repeat (400) @(posedge clk_sys);
		check(n_open, 32'h4);
		check(last_open, 8'h47);
		check(n_close, 32'h4);
		rd_reg(`OFS_STATUS, st);
		check(st & 32'h1, 32'h0);
		// Abort inside the trigger delay: back to idle, no relay moved
		wr_reg(`OFS_CTRL, 32'h1);
		wr_reg(`OFS_CTRL, 32'h2);
		repeat (40) @(posedge clk_sys);
		check(n_close, 32'h4);
		check(n_open, 32'h4);
		rd_reg(`OFS_STATUS, st);
		check(st & 32'h1, 32'h0);
		end_of_test;
	end
endmodule
